// *** core/backup_cfg_pkg.sv ***
package backup_cfg_pkg;

  // Register offsets on the byte register port
  localparam logic [7:0] ADDR_BUCK_OFF   = 8'h03;
  localparam logic [7:0] ADDR_UPPER      = 8'h04;
  localparam logic [7:0] ADDR_LOWER      = 8'h05;
  localparam logic [7:0] ADDR_CTRL       = 8'h06;
  localparam logic [7:0] ADDR_TIMER_HIGH = 8'h07;

  // Values after reset
  localparam logic [7:0] BUCK_OFF_RST = 8'h37;
  localparam logic [7:0] UPPER_RST    = 8'ha6;
  localparam logic [7:0] LOWER_RST    = 8'h8f;
  localparam logic [7:0] CTRL_RST     = 8'h01;
  localparam logic [7:0] TIMER_RST    = 8'h00;

  // Scale factors of the programmed codes
  localparam int BUCK_OFF_STEP_MV = 48;
  localparam int THRESH_STEP_MV   = 150;
  localparam int ESR_STEP_MV      = 50;

  // Timer resolution and clock rate
  localparam int TIMER_LSB_MS     = 2;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int TIMER_LSB_CYCLES = TIMER_LSB_MS * 1000000 / CLK_PERIOD_NS;
  localparam logic [15:0] TIMER_MAX = 16'hffff;

  // Control register layout, msb first
  typedef struct packed {
    logic       rsvd;
    logic       rev_hold;
    logic       meas_en;
    logic       burst;
    logic [1:0] esr_sel;
    logic [1:0] fsw_sel;
  } ctrl_fields_t;

  // One register access from the serial interface engine
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } reg_req_t;

  typedef enum logic [1:0] {
    TMR_IDLE       = 2'b00,
    TMR_WAIT_UPPER = 2'b01,
    TMR_COUNT      = 2'b10
  } tmr_state_t;

  // ESR limit in mV for a select code: 50, 100, 150, 200
  function automatic logic [7:0] esr_limit_mv(input logic [1:0] sel);
    esr_limit_mv = 8'(ESR_STEP_MV * (int'(sel) + 1));
  endfunction

endpackage

// *** core/discharge_timer.sv ***
`timescale 1ns/1ps
module discharge_timer import backup_cfg_pkg::*; #(
  parameter int TICK_CYCLES = TIMER_LSB_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        start,
  input  wire logic [7:0]  volt_code,
  input  wire logic [7:0]  upper_code,
  input  wire logic [7:0]  lower_code,
  output logic      [15:0] count,
  output logic             busy
);
  localparam int CNT_W = $clog2(TICK_CYCLES + 1);

  typedef struct packed {
    tmr_state_t       st;
    logic [CNT_W-1:0] tick;
    logic [15:0]      count;
    logic             busy;
  } tmr_reg_t;

  tmr_reg_t q;
  tmr_reg_t d;

  // Wait for the upper crossing, then count 2 ms units to the lower one
  always_comb begin
    d = q;
    case (q.st)
      TMR_WAIT_UPPER: begin
        if (volt_code <= upper_code) begin
          d.st   = TMR_COUNT;
          d.tick = '0;
        end
      end
      TMR_COUNT: begin
        if (volt_code <= lower_code) begin
          d.st = TMR_IDLE;
        end else if (q.tick == CNT_W'(TICK_CYCLES - 1)) begin
          d.tick = '0;
          // Saturate rather than wrap so a slow discharge reads full scale
          if (q.count != TIMER_MAX) begin
            d.count = q.count + 16'h0001;
          end
        end else begin
          d.tick = q.tick + CNT_W'(1);
        end
      end
      default: d.st = TMR_IDLE;
    endcase
    // A fresh start discards the held result
    if (start) begin
      d.st    = TMR_WAIT_UPPER;
      d.tick  = '0;
      d.count = 16'h0000;
    end
    // Busy kept in a flop so the top output needs no gate after it
    d.busy = (d.st != TMR_IDLE);
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{st: TMR_IDLE, tick: '0, count: 16'h0000, busy: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign count = q.count;
  assign busy  = q.busy;

  AST_TIMER_STEP: assert property (@(posedge clk) disable iff (rst)
    (q.st == TMR_COUNT && q.tick == CNT_W'(TICK_CYCLES - 1) && !start &&
     volt_code > lower_code && q.count != TIMER_MAX)
    |=> count == $past(count) + 16'h0001)
    else $error("Timer did not advance one unit per tick");

  AST_TIMER_HOLD: assert property (@(posedge clk) disable iff (rst)
    (q.st == TMR_IDLE && !start) |=> $stable(count))
    else $error("Timer result changed while idle");
endmodule

// *** core/esr_detector.sv ***
`timescale 1ns/1ps
module esr_detector import backup_cfg_pkg::*; (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       clear,
  input  wire logic [7:0] step_mv,
  input  wire logic       step_valid,
  input  wire logic [1:0] sel,
  output logic            error
);
  typedef struct packed {
    logic err;
  } esr_reg_t;

  esr_reg_t q;
  esr_reg_t d;

  // Verdict updated per measured step; a new measurement clears it
  always_comb begin
    d = q;
    if (clear) begin
      d.err = 1'b0;
    end
    if (step_valid) begin
      d.err = (step_mv > esr_limit_mv(sel));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      q <= '{err: 1'b0};
    end else begin
      q <= d;
    end
  end

  assign error = q.err;

  AST_ESR_VERDICT: assert property (@(posedge clk) disable iff (rst)
    step_valid |=> error == ($past(step_mv) > esr_limit_mv($past(sel))))
    else $error("ESR verdict does not match selected limit");
endmodule

// *** core/backup_threshold_config_regs.sv ***
`timescale 1ns/1ps
module backup_threshold_config_regs import backup_cfg_pkg::*; #(
  parameter int TICK_CYCLES = TIMER_LSB_CYCLES
) (
  input  wire logic        REF_CLK,
  input  wire logic        RESET,
  input  wire reg_req_t    REG_REQ,
  output logic      [7:0]  REG_RDATA,
  input  wire logic [7:0]  STORAGE_VOLT_CODE,
  input  wire logic        REVERSE_OVER_LIMIT,
  input  wire logic [7:0]  ESR_STEP_MV,
  input  wire logic        ESR_STEP_VALID,
  output logic      [7:0]  BUCK_OFF_CODE,
  output logic      [15:0] BUCK_OFF_MV,
  output logic      [15:0] UPPER_THRESH_MV,
  output logic      [15:0] LOWER_THRESH_MV,
  output logic             BOOST_BURST,
  output logic      [7:0]  ESR_THRESH_MV,
  output logic      [10:0] FSW_KHZ,
  output logic             BLOCK_SWITCH_OFF,
  output logic             MEASURE_START,
  output logic             MEASURE_BUSY,
  output logic             ESR_ERROR,
  output logic      [7:0]  DISCHARGE_TIMER_LOW
);

  // Switching frequency in kHz for a select code
  function automatic logic [10:0] fsw_khz(input logic [1:0] sel);
    case (sel)
      2'b00:   fsw_khz = 11'h0fa;
      2'b01:   fsw_khz = 11'h1f4;
      2'b10:   fsw_khz = 11'h3e8;
      default: fsw_khz = 11'h5dc;
    endcase
  endfunction

  // Code times step in mV; used for all three voltage codes
  function automatic logic [15:0] code_mv(input logic [7:0] code,
                                          input int         step);
    code_mv = 16'(int'(code) * step);
  endfunction

  typedef struct packed {
    logic [7:0]   buck_off;
    logic [7:0]   upper;
    logic [7:0]   lower;
    ctrl_fields_t ctrl;
    logic [7:0]   rdata;
    logic [15:0]  buck_mv;
    logic [15:0]  upper_mv;
    logic [15:0]  lower_mv;
    logic [7:0]   esr_mv;
    logic [10:0]  fsw;
    logic         sw_off;
    logic         start;
  } top_reg_t;

  top_reg_t q;
  top_reg_t d;

  logic [15:0] timer_count;
  logic        timer_busy;
  logic        esr_err;

  discharge_timer #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_timer (
    .clk        (REF_CLK),
    .rst        (RESET),
    .start      (q.start),
    .volt_code  (STORAGE_VOLT_CODE),
    .upper_code (q.upper),
    .lower_code (q.lower),
    .count      (timer_count),
    .busy       (timer_busy)
  );

  esr_detector u_esr (
    .clk        (REF_CLK),
    .rst        (RESET),
    .clear      (q.start),
    .step_mv    (ESR_STEP_MV),
    .step_valid (ESR_STEP_VALID),
    .sel        (q.ctrl.esr_sel),
    .error      (esr_err)
  );

  // Register writes, read data and derived controls
  always_comb begin
    d = q;
    if (REG_REQ.wr) begin
      if (REG_REQ.addr == ADDR_BUCK_OFF) begin
        d.buck_off = REG_REQ.wdata;
      end else if (REG_REQ.addr == ADDR_UPPER) begin
        d.upper = REG_REQ.wdata;
      end else if (REG_REQ.addr == ADDR_LOWER) begin
        d.lower = REG_REQ.wdata;
      end else if (REG_REQ.addr == ADDR_CTRL) begin
        d.ctrl      = ctrl_fields_t'(REG_REQ.wdata);
        d.ctrl.rsvd = 1'b0; // Reserved bit stays zero
      end
    end

    // Read data is registered; unmapped offsets read as zero
    d.rdata = 8'h00;
    if (REG_REQ.rd) begin
      if (REG_REQ.addr == ADDR_BUCK_OFF) begin
        d.rdata = q.buck_off;
      end else if (REG_REQ.addr == ADDR_UPPER) begin
        d.rdata = q.upper;
      end else if (REG_REQ.addr == ADDR_LOWER) begin
        d.rdata = q.lower;
      end else if (REG_REQ.addr == ADDR_CTRL) begin
        d.rdata = q.ctrl;
      end else if (REG_REQ.addr == ADDR_TIMER_HIGH) begin
        d.rdata = timer_count[15:8];
      end
    end

    // Only a rising edge starts; rewriting a one does nothing
    d.start = d.ctrl.meas_en & ~q.ctrl.meas_en;

    // Voltages in mV and switching frequency in kHz for the analog trims
    d.buck_mv  = code_mv(d.buck_off, BUCK_OFF_STEP_MV);
    d.upper_mv = code_mv(d.upper, THRESH_STEP_MV);
    d.lower_mv = code_mv(d.lower, THRESH_STEP_MV);
    d.esr_mv   = esr_limit_mv(d.ctrl.esr_sel);
    d.fsw      = fsw_khz(d.ctrl.fsw_sel);

    // Level follows the comparator; hold bit masks the cut-off entirely
    d.sw_off = REVERSE_OVER_LIMIT & ~q.ctrl.rev_hold;
  end

  always_ff @(posedge REF_CLK) begin
    if (RESET) begin
      q <= '{buck_off: BUCK_OFF_RST,
             upper:    UPPER_RST,
             lower:    LOWER_RST,
             ctrl:     ctrl_fields_t'(CTRL_RST),
             rdata:    8'h00,
             buck_mv:  code_mv(BUCK_OFF_RST, BUCK_OFF_STEP_MV),
             upper_mv: code_mv(UPPER_RST, THRESH_STEP_MV),
             lower_mv: code_mv(LOWER_RST, THRESH_STEP_MV),
             esr_mv:   esr_limit_mv(CTRL_RST[3:2]),
             fsw:      fsw_khz(CTRL_RST[1:0]),
             sw_off:   1'b0,
             start:    1'b0};
    end else begin
      q <= d;
    end
  end

  // Every output straight from a flop here or in a child
  assign REG_RDATA           = q.rdata;
  assign BUCK_OFF_CODE       = q.buck_off;
  assign BUCK_OFF_MV         = q.buck_mv;
  assign UPPER_THRESH_MV     = q.upper_mv;
  assign LOWER_THRESH_MV     = q.lower_mv;
  assign BOOST_BURST         = q.ctrl.burst;
  assign ESR_THRESH_MV       = q.esr_mv;
  assign FSW_KHZ             = q.fsw;
  assign BLOCK_SWITCH_OFF    = q.sw_off;
  assign MEASURE_START       = q.start;
  assign MEASURE_BUSY        = timer_busy;
  assign ESR_ERROR           = esr_err;
  assign DISCHARGE_TIMER_LOW = timer_count[7:0];

  // Sequences for the control register write and its effects
  sequence ctrl_write_s;
    REG_REQ.wr && REG_REQ.addr == ADDR_CTRL;
  endsequence

  sequence meas_rise_s;
    ctrl_write_s ##0 REG_REQ.wdata[5] && !q.ctrl.meas_en;
  endsequence

  AST_BUCK_RESET: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    $past(RESET) |-> BUCK_OFF_CODE == BUCK_OFF_RST &&
                     BUCK_OFF_MV == 16'h0a50)
    else $error("Buck-off code or voltage wrong after reset");

  AST_BUCK_SCALE: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (REG_REQ.wr && REG_REQ.addr == ADDR_BUCK_OFF)
    |=> BUCK_OFF_MV == 16'(int'($past(REG_REQ.wdata)) * 48))
    else $error("Buck-off voltage not code times 48 mV");

  AST_UPPER_RESET: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    $past(RESET) |-> UPPER_THRESH_MV == 16'h6144)
    else $error("Upper threshold not 24.9 V after reset");

  AST_LOWER_SCALE: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (REG_REQ.wr && REG_REQ.addr == ADDR_LOWER)
    |=> LOWER_THRESH_MV == 16'(int'($past(REG_REQ.wdata)) * 150))
    else $error("Lower threshold not code times 150 mV");

  AST_REV_CUT: assert property (@(posedge REF_CLK) disable iff (RESET)
    (REVERSE_OVER_LIMIT && !q.ctrl.rev_hold) |=> BLOCK_SWITCH_OFF)
    else $error("Block switch not opened on reverse current");

  AST_REV_HOLD: assert property (@(posedge REF_CLK) disable iff (RESET)
    q.ctrl.rev_hold |=> !BLOCK_SWITCH_OFF)
    else $error("Block switch opened while hold bit set");

  AST_MEAS_EDGE: assert property (@(posedge REF_CLK) disable iff (RESET)
    meas_rise_s |=> MEASURE_START ##1 !MEASURE_START)
    else $error("Measurement start not a single pulse on rising edge");

  AST_MEAS_ONLY_EDGE: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    MEASURE_START |-> q.ctrl.meas_en && !$past(q.ctrl.meas_en))
    else $error("Measurement started without a rising edge");

  AST_BOOST_MODE: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    ctrl_write_s |=> BOOST_BURST == $past(REG_REQ.wdata[4]))
    else $error("Boost mode does not follow bit 4");

  AST_ESR_LIMIT: assert property (@(posedge REF_CLK) disable iff (RESET)
    ctrl_write_s |=> ESR_THRESH_MV ==
      8'(50 * (int'($past(REG_REQ.wdata[3:2])) + 1)))
    else $error("ESR limit does not match select code");

  AST_FSW_MAP: assert property (@(posedge REF_CLK) disable iff (RESET)
    ctrl_write_s ##0 REG_REQ.wdata[1:0] == 2'b11 |=> FSW_KHZ == 11'h5dc)
    else $error("Code 3 does not give 1.5 MHz");

  AST_FSW_RESET: assert property (@(posedge REF_CLK) disable iff (RESET)
    $past(RESET) |-> FSW_KHZ == 11'h1f4 && ESR_THRESH_MV == 8'h32)
    else $error("Frequency or ESR limit wrong after reset");

  AST_TIMER_HIGH: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (REG_REQ.rd && REG_REQ.addr == ADDR_TIMER_HIGH)
    |=> REG_RDATA == $past(timer_count[15:8]))
    else $error("Timer high byte read mismatch");

  AST_TIMER_CLEAR: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    MEASURE_START |=> DISCHARGE_TIMER_LOW == 8'h00 && MEASURE_BUSY)
    else $error("Timer not cleared and armed by start");

  AST_BUCK_CODE: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (REG_REQ.wr && REG_REQ.addr == ADDR_BUCK_OFF)
    |=> BUCK_OFF_CODE == $past(REG_REQ.wdata))
    else $error("Buck-off code not stored on write");

  AST_UPPER_SCALE: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (REG_REQ.wr && REG_REQ.addr == ADDR_UPPER)
    |=> UPPER_THRESH_MV == 16'(int'($past(REG_REQ.wdata)) * 150))
    else $error("Upper threshold not code times 150 mV");

  AST_LOWER_RESET: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    $past(RESET) |-> LOWER_THRESH_MV == 16'h53ca)
    else $error("Lower threshold not 21.45 V after reset");

  AST_REV_CLEAR: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    !REVERSE_OVER_LIMIT |=> !BLOCK_SWITCH_OFF)
    else $error("Block switch open without reverse current");

  AST_MEAS_RESET: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    $past(RESET) |-> !MEASURE_START && !MEASURE_BUSY && !ESR_ERROR)
    else $error("Measurement active right after reset");

  AST_BOOST_RESET: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    $past(RESET) |-> !BOOST_BURST)
    else $error("Boost not in constant-voltage mode after reset");

  AST_FSW_LOW: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    ctrl_write_s ##0 REG_REQ.wdata[1:0] == 2'b00 |=> FSW_KHZ == 11'h0fa)
    else $error("Code 0 does not give 250 kHz");

  AST_FSW_MID: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    ctrl_write_s ##0 REG_REQ.wdata[1:0] == 2'b01 |=> FSW_KHZ == 11'h1f4)
    else $error("Code 1 does not give 500 kHz");

  AST_FSW_ONE_MHZ: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    ctrl_write_s ##0 REG_REQ.wdata[1:0] == 2'b10 |=> FSW_KHZ == 11'h3e8)
    else $error("Code 2 does not give 1 MHz");

  AST_TIMER_RESET: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    $past(RESET) |-> DISCHARGE_TIMER_LOW == 8'h00)
    else $error("Timer low byte not zero after reset");

  AST_ESR_CLEAR: assert property (@(posedge REF_CLK)
    disable iff (RESET)
    (MEASURE_START && !ESR_STEP_VALID) |=> !ESR_ERROR)
    else $error("ESR error not cleared by a new measurement");

endmodule

// *** sim/reg_host_model.sv ***
`timescale 1ns/1ps
module reg_host_model import backup_cfg_pkg::*; (
  input  wire logic       clk,
  input  wire logic [7:0] rdata,
  output reg_req_t        req
);
  // Idle strobes low; address and data start at zero
  initial begin
    req = '0;
  end

  // Idle bus shows the inverse of the last value, never a stale copy
  task automatic release_bus;
    req.wr    = 1'b0;
    req.rd    = 1'b0;
    req.addr  = ~req.addr;
    req.wdata = ~req.wdata;
  endtask

  // One write strobe, taken at the next rising edge
  task automatic write(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    #1;
    req.wr    = 1'b1;
    req.addr  = a;
    req.wdata = d;
    @(posedge clk);
    #1;
    release_bus();
  endtask

  // Read data stands only in the cycle after the taking edge
  task automatic read(input logic [7:0] a, output logic [7:0] d);
    @(posedge clk);
    #1;
    req.rd   = 1'b1;
    req.addr = a;
    @(posedge clk);
    #1;
    d = rdata;
    release_bus();
  endtask
endmodule

// *** sim/backup_threshold_config_regs_bench.sv ***
`timescale 1ns/1ps
module backup_threshold_config_regs_bench import backup_cfg_pkg::*; ;
  localparam int TICKS = 4;
  logic        ref_clk, reset, rev_over, esr_valid;
  reg_req_t    reg_req;
  logic [7:0]  reg_rdata, volt_code, esr_step, buck_code, esr_thr, tmr_low;
  logic [15:0] buck_mv, upper_mv, lower_mv;
  logic        burst, sw_off, m_start, m_busy, esr_err;
  logic [10:0] fsw;
  logic [7:0]  rd, v, c;
  int          fails, n_compared, seed, starts, s0, k;

  backup_threshold_config_regs #(
    .TICK_CYCLES(TICKS)
  ) u_backup_threshold_config_regs (
    .REF_CLK(ref_clk), .RESET(reset), .REG_REQ(reg_req),
    .REG_RDATA(reg_rdata), .STORAGE_VOLT_CODE(volt_code),
    .REVERSE_OVER_LIMIT(rev_over), .ESR_STEP_MV(esr_step),
    .ESR_STEP_VALID(esr_valid), .BUCK_OFF_CODE(buck_code),
    .BUCK_OFF_MV(buck_mv), .UPPER_THRESH_MV(upper_mv),
    .LOWER_THRESH_MV(lower_mv), .BOOST_BURST(burst),
    .ESR_THRESH_MV(esr_thr), .FSW_KHZ(fsw), .BLOCK_SWITCH_OFF(sw_off),
    .MEASURE_START(m_start), .MEASURE_BUSY(m_busy), .ESR_ERROR(esr_err),
    .DISCHARGE_TIMER_LOW(tmr_low));

  reg_host_model u_reg_host_model (
    .clk(ref_clk), .rdata(reg_rdata), .req(reg_req));

  // 100 MHz reference
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end

  // Counts start pulses, so a double or missing pulse shows up
  always @(posedge ref_clk) begin
    if (m_start === 1'b1) starts++;
  end

  function automatic logic [15:0] mv_of(input logic [7:0] x, input int step);
    mv_of = 16'(int'(x) * step);
  endfunction

  function automatic logic [10:0] fsw_of(input logic [1:0] s);
    case (s)
      2'h0: fsw_of = 11'h0fa;
      2'h1: fsw_of = 11'h1f4;
      2'h2: fsw_of = 11'h3e8;
      default: fsw_of = 11'h5dc;
    endcase
  endfunction

  task automatic check_eq(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_rng(input logic [15:0] got, lo, hi);
    n_compared++;
    if ((got >= lo && got <= hi) !== 1'b1) begin
      fails++;
      $display("wrong value at %0t: got %h expected %h..%h", $time, got,
               lo, hi);
    end
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    u_reg_host_model.read(a, rd);
    check_eq(16'(rd), 16'(exp));
  endtask

  task automatic tally_and_finish;
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Pulse one ESR sample and see the verdict one cycle later
  task automatic esr_try(input logic [7:0] s, input logic [7:0] lim);
    @(posedge ref_clk);
    #1;
    esr_step  = s;
    esr_valid = 1'b1;
    @(posedge ref_clk);
    #1;
    esr_valid = 1'b0;
    esr_step  = ~s;
    check_eq(16'(esr_err), 16'(s > lim));
  endtask

  initial begin
    seed = 82463;
    fails = 0;
    n_compared = 0;
    reset = 1'b1;
    volt_code = 8'hff;
    rev_over = 1'b0;
    esr_step = 8'h00;
    esr_valid = 1'b0;
    repeat (8) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    // Reset values, readback and decoded outputs
    rd_chk(ADDR_BUCK_OFF, 8'h37);
    rd_chk(ADDR_UPPER, 8'ha6);
    rd_chk(ADDR_LOWER, 8'h8f);
    rd_chk(ADDR_CTRL, 8'h01);
    rd_chk(ADDR_TIMER_HIGH, 8'h00);
    check_eq(buck_mv, mv_of(8'h37, BUCK_OFF_STEP_MV));
    check_eq(upper_mv, mv_of(8'ha6, THRESH_STEP_MV));
    check_eq(lower_mv, mv_of(8'h8f, THRESH_STEP_MV));
    check_eq(16'(burst), 16'h0000);
    check_eq(16'(esr_thr), 16'h0032);
    check_eq(16'(fsw), 16'(fsw_of(2'h1)));
    $display("reset values done");
    // Random codes with both extremes first
    for (int i = 0; i < 8; i++) begin
      c = (i == 0) ? 8'hff : (i == 1) ? 8'h00 : 8'($random(seed));
      u_reg_host_model.write(ADDR_BUCK_OFF, c);
      u_reg_host_model.write(ADDR_UPPER, ~c);
      u_reg_host_model.write(ADDR_LOWER, c ^ 8'h5a);
      rd_chk(ADDR_BUCK_OFF, c);
      rd_chk(ADDR_UPPER, ~c);
      rd_chk(ADDR_LOWER, c ^ 8'h5a);
      check_eq(16'(buck_code), 16'(c));
      check_eq(buck_mv, mv_of(c, BUCK_OFF_STEP_MV));
      check_eq(upper_mv, mv_of(~c, THRESH_STEP_MV));
      check_eq(lower_mv, mv_of(c ^ 8'h5a, THRESH_STEP_MV));
    end
    $display("threshold codes done");
    // Every ESR and frequency code, burst, reverse hold, bit 7 reads 0
    for (int i = 0; i < 16; i++) begin
      v = {1'b1, 1'(i >> 1), 1'b0, 1'($random(seed)), 4'(i)};
      rev_over = 1'($random(seed));
      u_reg_host_model.write(ADDR_CTRL, v);
      rd_chk(ADDR_CTRL, v & 8'h7f);
      check_eq(16'(burst), 16'(v[4]));
      check_eq(16'(esr_thr), mv_of(8'(v[3:2]) + 8'h01, ESR_STEP_MV));
      check_eq(16'(fsw), 16'(fsw_of(v[1:0])));
      check_eq(16'(sw_off), 16'(rev_over & ~v[6]));
    end
    rev_over = 1'b0;
    // Writes to the timer byte and unmapped places change nothing
    u_reg_host_model.write(ADDR_TIMER_HIGH, 8'h5a);
    u_reg_host_model.write(8'h20, 8'h77);
    rd_chk(ADDR_TIMER_HIGH, 8'h00);
    rd_chk(8'h20, 8'h00);
    $display("control field codes done");
    // Measurement: one start per rising edge of the enable bit
    u_reg_host_model.write(ADDR_UPPER, 8'h80);
    u_reg_host_model.write(ADDR_LOWER, 8'h40);
    u_reg_host_model.write(ADDR_CTRL, 8'h01);
    s0 = starts;
    u_reg_host_model.write(ADDR_CTRL, 8'h21);
    u_reg_host_model.write(ADDR_CTRL, 8'h21);
    check_eq(16'(starts - s0), 16'h0001);
    check_eq(16'(m_busy), 16'h0001);
    volt_code = 8'h60;
    repeat (300 * TICKS) @(posedge ref_clk);
    #1;
    volt_code = 8'h30;
    k = 0;
    // Bounded wait for the timer to stop
    while (m_busy !== 1'b0 && k < 20) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    if (k >= 20) begin
      fails++;
      tally_and_finish();
    end
    u_reg_host_model.read(ADDR_TIMER_HIGH, rd);
    check_rng({rd, tmr_low}, 16'h012b, 16'h012d);
    repeat (50) @(posedge ref_clk);
    #1;
    u_reg_host_model.read(ADDR_TIMER_HIGH, rd);
    check_rng({rd, tmr_low}, 16'h012b, 16'h012d);
    // Restart below the lower threshold clears the count
    u_reg_host_model.write(ADDR_CTRL, 8'h01);
    u_reg_host_model.write(ADDR_CTRL, 8'h21);
    repeat (10) @(posedge ref_clk);
    #1;
    rd_chk(ADDR_TIMER_HIGH, 8'h00);
    check_eq(16'(tmr_low), 16'h0000);
    check_eq(16'(starts - s0), 16'h0002);
    $display("discharge timer done");
    // ESR verdict at and just above each limit
    for (int i = 0; i < 4; i++) begin
      u_reg_host_model.write(ADDR_CTRL, 8'(i << 2));
      c = 8'(mv_of(8'(i + 1), ESR_STEP_MV));
      esr_try(c, c);
      esr_try(c + 8'h01, c);
      esr_try(8'($random(seed)), c);
    end
    // A new measurement start clears a standing ESR error
    esr_try(8'hff, 8'hc8);
    u_reg_host_model.write(ADDR_CTRL, 8'h20);
    repeat (2) @(posedge ref_clk);
    #1;
    check_eq(16'(esr_err), 16'h0000);
    $display("esr detection done");
    // Mid-run reset restores every register
    reset = 1'b1;
    repeat (2) @(posedge ref_clk);
    #1;
    reset = 1'b0;
    rd_chk(ADDR_CTRL, 8'h01);
    rd_chk(ADDR_BUCK_OFF, 8'h37);
    check_eq(lower_mv, mv_of(8'h8f, THRESH_STEP_MV));
    check_eq(16'(m_busy), 16'h0000);
    $display("mid-run reset done");
    tally_and_finish();
  end
endmodule
